// File: rtl/orfs_ramp_status.v
// Purpose: Output setpoint ramp generator with configuration and status registers.
// Assumes: Register port is a simple write strobe plus two read buses; master clock is a pin.
// Notes:   Setpoint codes are 12.5 mV units; threshold and delay registers live elsewhere.
`timescale 1ns/100ps
`include "orfs_defs.vh"

module orfs_ramp_status #(
  parameter CNT_W = 16,
  parameter MCLK_KHZ = 1000,
  parameter OFF_DLY_W = 24
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire mclk_i,
  input wire cfg_wr_i,
  input wire [7:0] cfg_wdata_i,
  input wire out_on_i,
  input wire [`ORFS_SP_W-1:0] target_i,
  input wire [OFF_DLY_W-1:0] off_delay_i,
  input wire overcur_trip_i,
  input wire undervolt_i,
  input wire highvolt_i,
  input wire overheat_i,
  input wire temp_warn_i,
  input wire follow_err_i,
  input wire out_good_i,
  output reg [7:0] ramp_config_o,
  output reg [7:0] protection_flags_o,
  output reg [`ORFS_SP_W-1:0] setpoint_o,
  output reg ramping_o,
  output reg switches_off_o
);

  // ----------------------------------------------------------------------
  // Rate lookup
  // ----------------------------------------------------------------------
  // Master clock edges per 12.5 mV step for a rate in tenths of V/ms.
  // Edges = 12.5 mV / rate * f_mclk = 125 * f_khz / (rate_tenths * 1000).
  function [CNT_W-1:0] step_div;
    input [2:0] code;
    reg [31:0] tenths;
    reg [31:0] q;
    begin
      tenths = 32'd1;
      case (code)
        3'h0: tenths = 32'd1;
        3'h1: tenths = 32'd2;
        3'h2: tenths = 32'd5;
        3'h3: tenths = 32'd10;
        3'h4: tenths = 32'd20;
        3'h5: tenths = 32'd50;
        3'h6: tenths = 32'd50;
        default: tenths = 32'd83;
      endcase
      q = (32'd125 * MCLK_KHZ) / (tenths * 32'd1000);
      if (q == 32'd0) begin
        q = 32'd1;
      end
      step_div = q[CNT_W-1:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Master clock synchroniser (three stages, change once 2nd and 3rd agree)
  // ----------------------------------------------------------------------
  reg [2:0] mclk_sync_r;
  reg mclk_lvl_r;
  reg mclk_edge_r;

  // Shared master clock is the only ramp timebase, keeping converters aligned.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mclk_sync_r <= 3'h0;
      mclk_lvl_r <= 1'b0;
      mclk_edge_r <= 1'b0;
    end else begin
      mclk_sync_r <= {mclk_sync_r[1:0], mclk_i};
      mclk_edge_r <= 1'b0;
      if (mclk_sync_r[1] == mclk_sync_r[2] && mclk_sync_r[2] != mclk_lvl_r) begin
        mclk_lvl_r <= mclk_sync_r[2];
        mclk_edge_r <= mclk_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Ramp configuration register
  // ----------------------------------------------------------------------
  // Bit 7 is forced to zero through the write mask.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ramp_config_o <= `ORFS_CFG_RESET;
    end else if (cfg_wr_i) begin
      ramp_config_o <= cfg_wdata_i & `ORFS_CFG_WMASK;
    end
  end

  wire ctl_en = ramp_config_o[`ORFS_ENA_BIT];
  wire [2:0] rise_code = ramp_config_o[`ORFS_RISE_HI:`ORFS_RISE_LO];
  wire [2:0] fall_code = ramp_config_o[`ORFS_FALL_HI:`ORFS_FALL_LO];

  // ----------------------------------------------------------------------
  // Ramp state machine
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_RAMP = 2'b01;
  localparam ST_HOLD = 2'b10;
  localparam ST_DOWN = 2'b11;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`ORFS_SP_W-1:0] goal_r;
  reg [OFF_DLY_W-1:0] hold_r;
  reg on_d_r;
  wire step;
  wire rising = (goal_r > setpoint_o);
  wire moving = (state_r == ST_RAMP || state_r == ST_DOWN) && (goal_r != setpoint_o);

  orfs_step_divider #(
    .CNT_W(CNT_W)
  ) u_div (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .mclk_edge_i(mclk_edge_r),
    .run_i(moving),
    .divisor_i(rising ? step_div(rise_code) : step_div(fall_code)),
    .step_o(step)
  );

  // Ramp-down time in master clock edges is approximated by counting steps, so the
  // hold time is the off delay less (setpoint codes * step edges * mclk period).
  // To keep logic small the hold is counted in master clock edges.
  // Both operands are widened to the hold width first so the product is never cut short.
  wire [OFF_DLY_W-1:0] sp_wide = {{(OFF_DLY_W-`ORFS_SP_W){1'b0}}, setpoint_o};
  wire [OFF_DLY_W-1:0] fall_wide = {{(OFF_DLY_W-CNT_W){1'b0}}, step_div(fall_code)};
  wire [OFF_DLY_W-1:0] down_edges = sp_wide * fall_wide;
  wire [OFF_DLY_W-1:0] hold_len = (off_delay_i > down_edges) ? (off_delay_i - down_edges) :
                                  {OFF_DLY_W{1'b0}};

  // Next state: turn-on ramps up, turn-off holds then ramps down.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (out_on_i && !on_d_r) begin
          state_nxt = ST_RAMP;
        end else if (!out_on_i && on_d_r) begin
          state_nxt = ST_HOLD;
        end
      end
      ST_RAMP: begin
        if (!out_on_i) begin
          state_nxt = ST_HOLD;
        end else if (setpoint_o == goal_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (out_on_i) begin
          state_nxt = ST_RAMP;
        end else if (hold_r == {OFF_DLY_W{1'b0}}) begin
          state_nxt = ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (out_on_i) begin
          state_nxt = ST_RAMP;
        end else if (setpoint_o == `ORFS_SP_ZERO) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State, goal, hold counter and setpoint.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ST_IDLE;
      goal_r <= `ORFS_SP_ZERO;
      hold_r <= {OFF_DLY_W{1'b0}};
      on_d_r <= 1'b0;
      setpoint_o <= `ORFS_SP_ZERO;
      ramping_o <= 1'b0;
      switches_off_o <= 1'b1;
    end else begin
      state_r <= state_nxt;
      on_d_r <= out_on_i;
      ramping_o <= moving;
      if (out_on_i) begin
        goal_r <= target_i;
        switches_off_o <= 1'b0;
      end else begin
        goal_r <= `ORFS_SP_ZERO;
      end
      if (state_r != ST_HOLD && state_nxt == ST_HOLD) begin
        hold_r <= ctl_en ? hold_len : off_delay_i;
      end else if (state_r == ST_HOLD && mclk_edge_r && hold_r != {OFF_DLY_W{1'b0}}) begin
        hold_r <= hold_r - {{(OFF_DLY_W-1){1'b0}}, 1'b1};
      end
      if (!ctl_en) begin
        // Without ramp control the setpoint jumps; turn-off waits the full delay.
        if (state_r == ST_DOWN || out_on_i) begin
          setpoint_o <= goal_r;
        end
      end else if (step && moving) begin
        if (rising) begin
          setpoint_o <= setpoint_o + `ORFS_SP_ONE;
        end else begin
          setpoint_o <= setpoint_o - `ORFS_SP_ONE;
        end
      end
      if (state_r == ST_DOWN && state_nxt == ST_IDLE) begin
        switches_off_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Protection status register
  // ----------------------------------------------------------------------
  // Overcurrent during turn-on includes capacitor charge current at the
  // selected rise rate; the comparator upstream sees the summed current.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      protection_flags_o <= `ORFS_ST_RESET;
    end else begin
      protection_flags_o[`ORFS_ST_TEMP] <= ~temp_warn_i;
      protection_flags_o[`ORFS_ST_GOOD] <= out_good_i;
      protection_flags_o[`ORFS_ST_FOLLOW] <= ~follow_err_i;
      protection_flags_o[`ORFS_ST_HEAT] <= ~overheat_i;
      protection_flags_o[`ORFS_ST_OVERCUR] <= ~overcur_trip_i;
      protection_flags_o[`ORFS_ST_UNDERV] <= ~undervolt_i;
      protection_flags_o[`ORFS_ST_HIGHV] <= ~highvolt_i;
      protection_flags_o[`ORFS_ST_PHASE] <= 1'b1;
    end
  end

endmodule // orfs_ramp_status

// File: shared/orfs_defs.vh
// Purpose: Constants for the output ramp and protection flag block.
// Assumes: 200 MHz system clock; master clock arrives as a pin.
// Notes:   Field positions, reset values and step sizes are named here.
`ifndef ORFS_DEFS_VH
`define ORFS_DEFS_VH

// ----------------------------------------------------------------------
// Ramp configuration fields
// ----------------------------------------------------------------------
`define ORFS_RISE_HI 6
`define ORFS_RISE_LO 4
`define ORFS_ENA_BIT 3
`define ORFS_FALL_HI 2
`define ORFS_FALL_LO 0
`define ORFS_CFG_RESET 8'h00
`define ORFS_CFG_WMASK 8'h7f

// ----------------------------------------------------------------------
// Protection flag bit positions (flags are active low)
// ----------------------------------------------------------------------
`define ORFS_ST_TEMP 7
`define ORFS_ST_GOOD 6
`define ORFS_ST_FOLLOW 5
`define ORFS_ST_HEAT 4
`define ORFS_ST_OVERCUR 3
`define ORFS_ST_UNDERV 2
`define ORFS_ST_HIGHV 1
`define ORFS_ST_PHASE 0
`define ORFS_ST_RESET 8'hff

// ----------------------------------------------------------------------
// Setpoint step: one code is 12.5 mV; setpoint width in bits.
// ----------------------------------------------------------------------
`define ORFS_STEP_UV 12500
`define ORFS_SP_W 8
`define ORFS_SP_ZERO 8'h00
`define ORFS_SP_ONE 8'h01

`endif

// File: rtl/orfs_step_divider.v
// Purpose: Counts master clock edges and pulses once per ramp step.
// Assumes: Edge pulse is already synchronised to sys_clk_i.
// Notes:   Divisor per rate code comes from the lookup function.
`timescale 1ns/100ps
module orfs_step_divider #(
  parameter CNT_W = 16
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire mclk_edge_i,
  input wire run_i,
  input wire [CNT_W-1:0] divisor_i,
  output reg step_o
);

  reg [CNT_W-1:0] cnt_r;

  // ----------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------
  // Counter restarts whenever the ramp is idle so each ramp begins aligned.
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= {CNT_W{1'b0}};
      step_o <= 1'b0;
    end else if (!run_i) begin
      cnt_r <= {CNT_W{1'b0}};
      step_o <= 1'b0;
    end else if (mclk_edge_i) begin
      if (cnt_r + {{(CNT_W-1){1'b0}}, 1'b1} >= divisor_i) begin
        cnt_r <= {CNT_W{1'b0}};
        step_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        step_o <= 1'b0;
      end
    end else begin
      step_o <= 1'b0;
    end
  end

endmodule // orfs_step_divider

// File: verif/orfs_ramp_status_asserts.sv
// Purpose: Port checks for orfs_ramp_status.
// Assumes: One clock domain, reset active low.
// Notes:   Flags are compared one cycle after their detector inputs.
`timescale 1ns/100ps
module orfs_ramp_status_asserts (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire cfg_wr_i,
  input wire [7:0] cfg_wdata_i,
  input wire out_on_i,
  input wire [7:0] target_i,
  input wire overcur_trip_i,
  input wire undervolt_i,
  input wire highvolt_i,
  input wire overheat_i,
  input wire temp_warn_i,
  input wire follow_err_i,
  input wire out_good_i,
  input wire [7:0] ramp_config_o,
  input wire [7:0] protection_flags_o,
  input wire [7:0] setpoint_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // Ramp control enable as currently configured.
  wire en = ramp_config_o[3];
  // Register fields, flag encoding and ramp motion.
  a_cfg_write_taken: assert property (cfg_wr_i |=> ramp_config_o == {1'b0, $past(cfg_wdata_i[6:0])})
    else $error("config write not taken");
  a_cfg_top_zero: assert property (ramp_config_o[7] == 1'b0)
    else $error("config bit 7 set");
  a_phase_flag_idle: assert property (protection_flags_o[0] == 1'b1)
    else $error("phase flag active");
  a_flags_follow: assert property ($past(nrst_i) |-> protection_flags_o[7:1] == ~$past({temp_warn_i,
    ~out_good_i, follow_err_i, overheat_i, overcur_trip_i, undervolt_i, highvolt_i}))
    else $error("flags do not follow detectors");
  a_one_code_step: assert property (en && $past(en) && $past(nrst_i) && $changed(setpoint_o)
    |-> (setpoint_o - $past(setpoint_o) == 8'h01) || ($past(setpoint_o) - setpoint_o == 8'h01))
    else $error("setpoint moved more than one code");
  a_step_spacing: assert property (en && $past(en) && $changed(setpoint_o) |=> $stable(setpoint_o))
    else $error("steps closer than a master clock edge");
  a_hold_target: assert property (en && out_on_i && setpoint_o == target_i && $stable(target_i)
    && $stable(out_on_i) |=> $stable(setpoint_o))
    else $error("setpoint left its target");
  a_jump_direct: assert property (!en && out_on_i ##1 (!en && out_on_i && $stable(target_i))[*3]
    |-> setpoint_o == target_i)
    else $error("no direct jump with ramp control off");
endmodule // orfs_ramp_status_asserts

bind orfs_ramp_status orfs_ramp_status_asserts i_orfs_ramp_status_asserts (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i),
  .out_on_i(out_on_i), .target_i(target_i), .overcur_trip_i(overcur_trip_i), .undervolt_i(undervolt_i),
  .highvolt_i(highvolt_i), .overheat_i(overheat_i), .temp_warn_i(temp_warn_i), .follow_err_i(follow_err_i),
  .out_good_i(out_good_i), .ramp_config_o(ramp_config_o), .protection_flags_o(protection_flags_o),
  .setpoint_o(setpoint_o));

// File: verif/orfs_mgr_model.sv
// Purpose: Power manager stand-in that drives the shared master clock.
// Assumes: One model feeds every converter, so all ramps share its edges.
// Notes:   The clock rests low while run_i is low.
`timescale 1ns/100ps
module orfs_mgr_model #(
  parameter HALF_NS = 500
) (
  input wire run_i,
  output reg mclk_o
);
  // Offset start keeps its phase unrelated to the system clock.
  initial begin
    mclk_o = 1'b0;
    #3.3;
    forever begin
      #(HALF_NS) mclk_o = run_i ? ~mclk_o : 1'b0;
    end
  end
endmodule // orfs_mgr_model

// File: verif/orfs_ramp_status_tb.sv
// Purpose: Self-checking bench for orfs_ramp_status.
// Assumes: 1 MHz master clock, so one edge is 200 system cycles.
// Notes:   Seeded random config and flags plus timed ramps for rate codes 7 down to 3.
`timescale 1ns/100ps
module orfs_ramp_status_tb;
  reg sys_clk_i, nrst_i, cfg_wr_i, out_on_i, run;
  reg [7:0] cfg_wdata_i, target_i;
  reg [23:0] off_delay_i;
  reg [6:0] det; // Temp, good, follow, heat, overcur, underv, highv.
  reg [2:0] code;
  wire mclk_i, ramping_o, switches_off_o;
  wire [7:0] ramp_config_o, protection_flags_o, setpoint_o;
  integer mismatches, comparisons, seed, i, d, t0;
  orfs_mgr_model i_orfs_mgr_model (.run_i(run), .mclk_o(mclk_i));
  orfs_ramp_status i_orfs_ramp_status (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .mclk_i(mclk_i),
    .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .out_on_i(out_on_i), .target_i(target_i),
    .off_delay_i(off_delay_i), .overcur_trip_i(det[2]), .undervolt_i(det[1]), .highvolt_i(det[0]),
    .overheat_i(det[3]), .temp_warn_i(det[6]), .follow_err_i(det[4]), .out_good_i(det[5]),
    .ramp_config_o(ramp_config_o), .protection_flags_o(protection_flags_o), .setpoint_o(setpoint_o),
    .ramping_o(ramping_o), .switches_off_o(switches_off_o));
  // Active flags read low; output good is low when the output is not good.
  function [7:0] exp_flags(input [6:0] v);
    exp_flags = {~v[6], v[5], ~v[4:0], 1'b1};
  endfunction
  // A 12.5 mV step at tenths of V/ms lasts 125/tenths master edges.
  function integer edges(input [2:0] c);
    integer t;
    t = (c == 0) ? 1 : (c == 1) ? 2 : (c == 2) ? 5 : (c == 3) ? 10 : (c == 4) ? 20 : (c == 7) ? 83 : 50;
    edges = (125 / t < 1) ? 1 : 125 / t;
  endfunction
  task check_val(input [8*10:1] what, input [7:0] exp, input [7:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
    end
  endtask
  // Durations carry master clock phase and sync delay, hence the tolerance.
  task check_time(input [8*10:1] what, input integer exp, input integer tol, input integer got);
    comparisons = comparisons + 1;
    if (got < exp - tol || got > exp + tol) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %0s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task wait_move(input integer limit);
    reg [7:0] s;
    s = setpoint_o;
    d = 0;
    while (setpoint_o === s && d < limit) begin
      @(negedge sys_clk_i);
      d = d + 1;
    end
  endtask
  task wr_cfg(input [7:0] v);
    cfg_wdata_i = v;
    cfg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    cfg_wr_i = 1'b0;
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // Watchdog well above the roughly 30000 cycles the tests need.
  initial begin
    #250000;
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    {nrst_i, cfg_wr_i, out_on_i, cfg_wdata_i, target_i, off_delay_i} = 0;
    det = 7'h20;
    run = 1'b1;
    seed = 55848;
    mismatches = 0;
    comparisons = 0;
    repeat (4) @(negedge sys_clk_i);
    check_val("rst cfg", 8'h00, ramp_config_o);
    check_val("rst flags", 8'hff, protection_flags_o);
    check_val("rst off", 8'h01, {7'h00, switches_off_o});
    nrst_i = 1'b1;
    // Back-to-back writes with random detector levels, bit 7 set first.
    for (i = 0; i < 20; i = i + 1) begin
      cfg_wr_i = 1'b1;
      cfg_wdata_i = (i == 0) ? 8'hff : (i == 1) ? 8'h80 : $random(seed);
      det = $random(seed);
      @(negedge sys_clk_i);
      check_val("config", {1'b0, cfg_wdata_i[6:0]}, ramp_config_o);
      check_val("flags", exp_flags(det), protection_flags_o);
    end
    // Ramp control off: direct jump on, drop after the whole off delay.
    wr_cfg(8'h00);
    target_i = $random(seed) | 8'h01;
    out_on_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    check_val("jump", target_i, setpoint_o);
    off_delay_i = 24'h3;
    out_on_i = 1'b0;
    wait_move(2000);
    check_time("off delay", 600, 220, d);
    det = 7'h24; // Limits set by the manager make overcurrent trip during turn-on.
    // Codes 7 down to 3 for both directions.
    for (i = 0; i < 5; i = i + 1) begin
      code = 3'h7 - i;
      wr_cfg({1'b0, code, 1'b1, code});
      target_i = 8'h03;
      out_on_i = 1'b1;
      wait_move(30000);
      check_val("ramping", 8'h01, {7'h00, ramping_o});
      wait_move(30000);
      check_time("rise step", 200 * edges(code), 10, d);
      wait_move(30000);
      repeat (20) @(negedge sys_clk_i);
      check_val("top", target_i, setpoint_o);
      check_val("settled", 8'h00, {7'h00, ramping_o});
      check_val("trip", exp_flags(det), protection_flags_o);
      off_delay_i = 3 * edges(code) + 2;
      out_on_i = 1'b0;
      t0 = 0;
      repeat (3) begin
        wait_move(30000);
        t0 = t0 + d;
      end
      check_time("fall step", 200 * edges(code), 10, d);
      check_time("off ramp", 200 * off_delay_i, 220, t0);
      repeat (10) @(negedge sys_clk_i);
      check_val("zero", 8'h00, setpoint_o);
      check_val("off", 8'h01, {7'h00, switches_off_o});
    end
    nrst_i = 1'b0;
    @(negedge sys_clk_i);
    check_val("rst cfg", 8'h00, ramp_config_o);
    check_val("rst flags", 8'hff, protection_flags_o);
    final_report;
  end
endmodule // orfs_ramp_status_tb
